// >>> core/meter_event_pkg.sv
// constants for the meter event mask and per-phase flag block
// assumes a plain register port and one clock; detectors sit outside
// What this block does
// - mask bit 14 enables interrupt on phase C current zero crossing
// - mask bit 15 writable but inert; reset-complete interrupt is never masked
// - mask bit 16 enables voltage dip interrupt, phases shown in bits 14:12
// - mask bit 17 enables excess current interrupt, phases shown in bits 5:3
// - mask bit 18 enables excess voltage interrupt, phases shown in bits 11:9
// - mask bit 19: rising A crossing followed by C before B interrupts
// - mask bit 20: mismatch of current sum and neutral over limit interrupts
// - mask bit 23 enables interrupt at end of current peak period
// - mask bit 24 enables interrupt at end of voltage peak period
// - mask bits 22:21 and 31:25 do nothing; all mask bits reset to zero
// - phase bits 3,4,5 set when phase A,B,C current raises excess current
// - phase bits 9,10,11 set when phase A,B,C voltage raises excess voltage
// - phase bits 12,13,14 set when phase A,B,C voltage raises voltage dip
// - phase bits 2:0, 8:6, 15 read zero; defined bits reset to zero
// - idle bits 0..2 show per-phase total power no-load, with status bit 0
// - idle bits 3..5 show fundamental power no-load, with status bit 1
// - idle bits 6..8 show apparent power no-load, with status bit 2
// - a per-phase idle bit reads 0 once the phase leaves no-load
// - without fundamental measurement, idle bits 3..5 always read zero
// - idle bits 15:9 read zero; defined idle bits reset to zero
// - mask bit 0 enables interrupt when any phase enters total no-load
package meter_event_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [15:0] ADDR_EVENT_ENABLE_SECOND = 16'hE50B;
    localparam logic [15:0] ADDR_PHASE_EVENT_SOURCE = 16'hE600;
    localparam logic [15:0] ADDR_PHASE_IDLE_STATE = 16'hE608;
    localparam logic [15:0] ADDR_EVENT_STATUS_SECOND = 16'hE510;
    localparam logic [15:0] ADDR_CURRENT_SUM_LIMIT = 16'hE520;
    // ****************************************
    // status and mask bit positions
    // ****************************************
    localparam int ST_TOTAL_IDLE = 0;
    localparam int ST_FUND_IDLE = 1;
    localparam int ST_APP_IDLE = 2;
    localparam int ST_ZERO_CROSS_IC = 14;
    localparam int ST_RESET_DONE = 15;
    localparam int ST_DIP = 16;
    localparam int ST_EXCESS_CUR = 17;
    localparam int ST_EXCESS_VOLT = 18;
    localparam int ST_SEQ = 19;
    localparam int ST_MISMATCH = 20;
    localparam int ST_PEAK_CUR = 23;
    localparam int ST_PEAK_VOLT = 24;
    localparam logic [31:0] MASK_WRITABLE = 32'h019F_FFFF;
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    // ****************************************
    // phase source and idle fields (lsb of each 3-bit group)
    // ****************************************
    localparam int GROUP_W = 3;
    localparam int PH_EXCESS_CUR_LSB = 3;
    localparam int PH_EXCESS_VOLT_LSB = 9;
    localparam int PH_DIP_LSB = 12;
    localparam int IDLE_TOTAL_LSB = 0;
    localparam int IDLE_FUND_LSB = 3;
    localparam int IDLE_APP_LSB = 6;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [2:0] PHASES_NONE = 3'h0;
    // ****************************************
    // phase order watcher
    // ****************************************
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_AFTER_A} seq_state_t;
endpackage

// >>> core/meter_event_mask_and_phase_flags.sv
// event status, enable mask, irq and per-phase flag registers
// assumes detector pulses and levels synchronous to clk, one cycle wide pulses
`timescale 1ns/10ps
module meter_event_mask_and_phase_flags #(
    parameter int DATA_W = 24,
    parameter bit HAS_FUNDAMENTAL = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [31:0] rdData,
    output logic irq,
    input wire logic zeroCrossIc,
    input wire logic [2:0] dipPhase,
    input wire logic [2:0] excessCurrentPhase,
    input wire logic [2:0] excessVoltagePhase,
    input wire logic riseVa,
    input wire logic riseVb,
    input wire logic riseVc,
    input wire logic sampleValid,
    input wire logic signed [DATA_W-1:0] phaseCurrentSum,
    input wire logic signed [DATA_W-1:0] neutralCurrentWave,
    input wire logic currentPeakDone,
    input wire logic voltagePeakDone,
    input wire logic [2:0] totalIdle,
    input wire logic [2:0] fundIdle,
    input wire logic [2:0] apparentIdle
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [DATA_W:0] magnitude(input logic signed [DATA_W-1:0] v);
        logic signed [DATA_W:0] wide;
        wide = {v[DATA_W-1], v};
        magnitude = wide[DATA_W] ? (DATA_W+1)'(0) - wide : wide;
    endfunction

    function automatic logic addrIs(input logic [15:0] a, input logic [15:0] target);
        addrIs = (a == target);
    endfunction

    function automatic logic [2:0] stickyGroup(input logic clr, input logic [2:0] old,
        input logic [2:0] hit);
        stickyGroup = (clr ? meter_event_pkg::PHASES_NONE : old) | hit;
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [31:0] mask_ff;
    logic [31:0] status_ff;
    logic [15:0] phaseSource_ff;
    logic [15:0] idleState_ff;
    logic [8:0] idlePrev_ff;
    logic [DATA_W-1:0] sumLimit_ff;
    logic resetSeen_ff;
    logic [31:0] rdData_ff;
    meter_event_pkg::seq_state_t seq_ff;
    meter_event_pkg::seq_state_t nxt_seq;

    // ****************************************
    // register decode
    // ****************************************
    wire selMask = addrIs(addr, meter_event_pkg::ADDR_EVENT_ENABLE_SECOND);
    wire selSource = addrIs(addr, meter_event_pkg::ADDR_PHASE_EVENT_SOURCE);
    wire selIdle = addrIs(addr, meter_event_pkg::ADDR_PHASE_IDLE_STATE);
    wire selStatus = addrIs(addr, meter_event_pkg::ADDR_EVENT_STATUS_SECOND);
    wire selLimit = addrIs(addr, meter_event_pkg::ADDR_CURRENT_SUM_LIMIT);
    wire wrMask = wrStrobe & selMask;
    wire wrStatus = wrStrobe & selStatus;
    wire wrLimit = wrStrobe & selLimit;
    // status clears by writing ones; a write elsewhere clears nothing
    wire [31:0] statusClear = wrStatus ? wrData : 32'h0000_0000;

    // ****************************************
    // phase order watcher
    // ****************************************
    // rising C before B after A is a reversed sequence; B restores order
    logic seqFault;
    always_comb begin
        nxt_seq = seq_ff;
        seqFault = 1'b0;
        case (seq_ff)
            meter_event_pkg::SEQ_IDLE: begin
                if (riseVa) begin
                    nxt_seq = meter_event_pkg::SEQ_AFTER_A;
                end
            end
            meter_event_pkg::SEQ_AFTER_A: begin
                if (riseVc & ~riseVb) begin
                    seqFault = 1'b1;
                    nxt_seq = meter_event_pkg::SEQ_IDLE;
                end else if (riseVb) begin
                    nxt_seq = meter_event_pkg::SEQ_IDLE;
                end
            end
            default: begin
                nxt_seq = meter_event_pkg::SEQ_IDLE;
            end
        endcase
    end

    // ****************************************
    // neutral mismatch compare
    // ****************************************
    wire [DATA_W:0] sumMag = magnitude(phaseCurrentSum);
    wire [DATA_W:0] neutralMag = magnitude(neutralCurrentWave);
    wire [DATA_W:0] diffMag = (sumMag >= neutralMag) ? sumMag - neutralMag
                                                    : neutralMag - sumMag;
    wire mismatch = sampleValid & (diffMag > {1'b0, sumLimit_ff});

    // ****************************************
    // no-load levels
    // ****************************************
    // variants without fundamental measurement never report that state
    wire [2:0] fundIdleEff = HAS_FUNDAMENTAL ? fundIdle : meter_event_pkg::PHASES_NONE;
    wire [8:0] idleNow = {apparentIdle, fundIdleEff, totalIdle};
    wire [8:0] idleEnter = idleNow & ~idlePrev_ff;

    // ****************************************
    // event decode
    // ****************************************
    // events are recorded whatever the mask says
    localparam int GW = meter_event_pkg::GROUP_W;
    wire totalEnter = |idleEnter[meter_event_pkg::IDLE_TOTAL_LSB +: GW];
    wire fundEnter = |idleEnter[meter_event_pkg::IDLE_FUND_LSB +: GW];
    wire appEnter = |idleEnter[meter_event_pkg::IDLE_APP_LSB +: GW];
    // reset-done is raised once, on the first edge after reset lets go
    wire resetDone = ~resetSeen_ff;
    wire anyDip = |dipPhase;
    wire anyExcessCur = |excessCurrentPhase;
    wire anyExcessVolt = |excessVoltagePhase;

    // ****************************************
    // status set vector
    // ****************************************
    logic [31:0] statusSet;
    always_comb begin
        statusSet = meter_event_pkg::STATUS_RESET;
        // no-load entries
        statusSet[meter_event_pkg::ST_TOTAL_IDLE] = totalEnter;
        statusSet[meter_event_pkg::ST_FUND_IDLE] = fundEnter;
        statusSet[meter_event_pkg::ST_APP_IDLE] = appEnter;
        // line events
        statusSet[meter_event_pkg::ST_ZERO_CROSS_IC] = zeroCrossIc;
        statusSet[meter_event_pkg::ST_RESET_DONE] = resetDone;
        statusSet[meter_event_pkg::ST_DIP] = anyDip;
        statusSet[meter_event_pkg::ST_EXCESS_CUR] = anyExcessCur;
        statusSet[meter_event_pkg::ST_EXCESS_VOLT] = anyExcessVolt;
        statusSet[meter_event_pkg::ST_SEQ] = seqFault;
        statusSet[meter_event_pkg::ST_MISMATCH] = mismatch;
        // peak timing events
        statusSet[meter_event_pkg::ST_PEAK_CUR] = currentPeakDone;
        statusSet[meter_event_pkg::ST_PEAK_VOLT] = voltagePeakDone;
    end

    // ****************************************
    // status clear and hold
    // ****************************************
    wire [31:0] statusKept = status_ff & ~statusClear;
    // set wins over a clear arriving in the same cycle
    wire [31:0] nxt_status = statusKept | statusSet;

    // ****************************************
    // phase source flags
    // ****************************************
    // a phase group empties when software clears its status bit
    wire clrExcessCur = statusClear[meter_event_pkg::ST_EXCESS_CUR];
    wire clrExcessVolt = statusClear[meter_event_pkg::ST_EXCESS_VOLT];
    wire clrDip = statusClear[meter_event_pkg::ST_DIP];
    wire [2:0] curOld = phaseSource_ff[meter_event_pkg::PH_EXCESS_CUR_LSB +: GW];
    wire [2:0] voltOld = phaseSource_ff[meter_event_pkg::PH_EXCESS_VOLT_LSB +: GW];
    wire [2:0] dipOld = phaseSource_ff[meter_event_pkg::PH_DIP_LSB +: GW];
    wire [2:0] curNew = stickyGroup(clrExcessCur, curOld, excessCurrentPhase);
    wire [2:0] voltNew = stickyGroup(clrExcessVolt, voltOld, excessVoltagePhase);
    wire [2:0] dipNew = stickyGroup(clrDip, dipOld, dipPhase);
    logic [15:0] nxt_phaseSource;
    always_comb begin
        nxt_phaseSource = meter_event_pkg::FLAGS_RESET;
        nxt_phaseSource[meter_event_pkg::PH_EXCESS_CUR_LSB +: GW] = curNew;
        nxt_phaseSource[meter_event_pkg::PH_EXCESS_VOLT_LSB +: GW] = voltNew;
        nxt_phaseSource[meter_event_pkg::PH_DIP_LSB +: GW] = dipNew;
    end

    // ****************************************
    // idle state flags
    // ****************************************
    logic [15:0] nxt_idleState;
    always_comb begin
        nxt_idleState = meter_event_pkg::FLAGS_RESET;
        nxt_idleState[meter_event_pkg::IDLE_TOTAL_LSB +: GW] = totalIdle;
        nxt_idleState[meter_event_pkg::IDLE_FUND_LSB +: GW] = fundIdleEff;
        nxt_idleState[meter_event_pkg::IDLE_APP_LSB +: GW] = apparentIdle;
    end

    // ****************************************
    // enable mask
    // ****************************************
    // reserved mask bits are not stored, so they read zero and drive nothing
    wire [31:0] nxt_mask = wrMask ? (wrData & meter_event_pkg::MASK_WRITABLE) : mask_ff;
    logic [31:0] maskEff;
    always_comb begin
        maskEff = mask_ff;
        // reset-complete cannot be masked; its stored bit is ignored
        maskEff[meter_event_pkg::ST_RESET_DONE] = 1'b1;
    end

    // ****************************************
    // interrupt
    // ****************************************
    wire [31:0] irqSources = status_ff & maskEff;
    // irq is a level; it drops in the same cycle as the last enabled status bit clears
    assign irq = |irqSources;

    // ****************************************
    // read words
    // ****************************************
    // 16-bit registers sit in the low half; the upper half reads zero
    wire [31:0] srcWord = {16'h0000, phaseSource_ff};
    wire [31:0] idleWord = {16'h0000, idleState_ff};
    wire [31:0] limitWord = 32'(sumLimit_ff);

    // ****************************************
    // read mux
    // ****************************************
    // unmapped or idle cycles give zero, so stale words never linger on the bus
    logic [31:0] nxt_rdData;
    always_comb begin
        nxt_rdData = 32'h0000_0000;
        if (rdStrobe) begin
            if (selMask) begin
                nxt_rdData = mask_ff;
            end else if (selStatus) begin
                nxt_rdData = status_ff;
            end else if (selSource) begin
                nxt_rdData = srcWord;
            end else if (selIdle) begin
                nxt_rdData = idleWord;
            end else if (selLimit) begin
                nxt_rdData = limitWord;
            end
        end
    end
    assign rdData = rdData_ff;

    // ****************************************
    // software registers
    // ****************************************
    // the limit is kept at compare width; upper write bits are dropped
    wire [DATA_W-1:0] nxt_sumLimit = wrLimit ? wrData[DATA_W-1:0] : sumLimit_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_ff <= meter_event_pkg::MASK_RESET;
        end else begin
            mask_ff <= nxt_mask;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sumLimit_ff <= '0;
        end else begin
            sumLimit_ff <= nxt_sumLimit;
        end
    end

    // read data lasts one cycle, then returns to zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdData_ff <= 32'h0000_0000;
        end else begin
            rdData_ff <= nxt_rdData;
        end
    end

    // ****************************************
    // event records
    // ****************************************
    // status and flag groups share one reset so they never disagree after it
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            status_ff <= meter_event_pkg::STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phaseSource_ff <= meter_event_pkg::FLAGS_RESET;
        end else begin
            phaseSource_ff <= nxt_phaseSource;
        end
    end

    // idle flags follow the levels; no software clear is needed
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idleState_ff <= meter_event_pkg::FLAGS_RESET;
        end else begin
            idleState_ff <= nxt_idleState;
        end
    end

    // ****************************************
    // history
    // ****************************************
    // an idle level already high at release counts as an entry
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            idlePrev_ff <= '0;
        end else begin
            idlePrev_ff <= idleNow;
        end
    end

    // stays high until the next reset, so reset-done is raised once
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resetSeen_ff <= 1'b0;
        end else begin
            resetSeen_ff <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            seq_ff <= meter_event_pkg::SEQ_IDLE;
        end else begin
            seq_ff <= nxt_seq;
        end
    end
endmodule

// >>> verif/meter_event_sva.sv
// checker for the meter event mask block, bound to the design's ports
// assumes one clock, asynchronous active-high reset, one-cycle strobes
`timescale 1ns/10ps
module meter_event_sva (
    input wire logic clk,
    input wire logic reset,
    input wire logic [15:0] addr,
    input wire logic [31:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    input wire logic [31:0] rdData,
    input wire logic irq,
    input wire logic zeroCrossIc,
    input wire logic [2:0] dipPhase,
    input wire logic [2:0] excessCurrentPhase,
    input wire logic [2:0] excessVoltagePhase,
    input wire logic currentPeakDone,
    input wire logic voltagePeakDone
);
    // ****************************************
    // mask shadow and properties
    // ****************************************
    // shadow kept from the bus so irq can be tied to its cause
    logic [31:0] maskShadow_ff;
    wire logic maskWr = wrStrobe && (addr == meter_event_pkg::ADDR_EVENT_ENABLE_SECOND);
    wire logic [31:0] m = maskShadow_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            maskShadow_ff <= meter_event_pkg::MASK_RESET;
        end else if (maskWr) begin
            maskShadow_ff <= wrData & meter_event_pkg::MASK_WRITABLE;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    property p_zx; zeroCrossIc && m[14] && !maskWr |=> irq; endproperty
    a_zx: assert property (p_zx) else $error("zero cross irq missing");
    property p_lvl; (|dipPhase && m[16] || |excessCurrentPhase && m[17]
        || |excessVoltagePhase && m[18]) && !maskWr |=> irq; endproperty
    a_lvl: assert property (p_lvl) else $error("level event irq missing");
    property p_pki; currentPeakDone && m[23] && !maskWr |=> irq; endproperty
    a_pki: assert property (p_pki) else $error("current peak irq missing");
    property p_pkv; voltagePeakDone && m[24] && !maskWr |=> irq; endproperty
    a_pkv: assert property (p_pkv) else $error("voltage peak irq missing");
    property p_rdz; !$past(rdStrobe) |-> rdData == 32'h0000_0000; endproperty
    a_rdz: assert property (p_rdz) else $error("read data not idle");
    property p_msk; rdStrobe && addr == meter_event_pkg::ADDR_EVENT_ENABLE_SECOND
        |=> rdData == $past(m); endproperty
    a_msk: assert property (p_msk) else $error("mask readback wrong");
    property p_src; rdStrobe && addr == meter_event_pkg::ADDR_PHASE_EVENT_SOURCE
        |=> (rdData & 32'hFFFF_81C7) == 32'h0000_0000; endproperty
    a_src: assert property (p_src) else $error("phase source loose bit set");
    property p_idl; rdStrobe && addr == meter_event_pkg::ADDR_PHASE_IDLE_STATE
        |=> (rdData & 32'hFFFF_FE00) == 32'h0000_0000; endproperty
    a_idl: assert property (p_idl) else $error("idle state loose bit set");
endmodule
bind meter_event_mask_and_phase_flags meter_event_sva chk_u (.clk, .reset, .addr, .wrData,
    .wrStrobe, .rdStrobe, .rdData, .irq, .zeroCrossIc, .dipPhase, .excessCurrentPhase,
    .excessVoltagePhase, .currentPeakDone, .voltagePeakDone);

// >>> verif/tb_top.sv
// self-checking bench for the meter event mask and phase flag block
// assumes the checker binds itself; the bench drives every design input
`timescale 1ns/10ps
module tb_top;
    // ****************************************
    // stimulus, model and checks
    // ****************************************
    logic clk = 1'b0, reset = 1'b1, wrStrobe = 1'b0, rdStrobe = 1'b0, irq;
    logic [15:0] addr = 16'h0000, ev = 16'h0000;
    logic [31:0] wrData = 32'h0000_0000, rdData, rdDataNf;
    logic [2:0] totalIdle = 3'h0, fundIdle = 3'h0, apparentIdle = 3'h0;
    logic signed [23:0] phaseCurrentSum = 24'h000000, neutralCurrentWave = 24'h000000;
    int err_total = 0, compares = 0, expMask = 0, expStat = 0, expSrc = 0, v;
    int srcLsb[3] = '{12, 3, 9};
    int evBit[3] = '{0, 14, 15};
    int stBit[3] = '{14, 23, 24};
    always #12.5 clk = ~clk;
    meter_event_mask_and_phase_flags #(.DATA_W(24), .HAS_FUNDAMENTAL(1'b1)) dut_u (
        .clk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData, .irq,
        .zeroCrossIc(ev[0]), .dipPhase(ev[3:1]), .excessCurrentPhase(ev[6:4]),
        .excessVoltagePhase(ev[9:7]), .riseVa(ev[10]), .riseVb(ev[11]), .riseVc(ev[12]),
        .sampleValid(ev[13]), .phaseCurrentSum, .neutralCurrentWave, .currentPeakDone(ev[14]),
        .voltagePeakDone(ev[15]), .totalIdle, .fundIdle, .apparentIdle);
    // variant without fundamental measurement, read in step with dut_u
    meter_event_mask_and_phase_flags #(.DATA_W(24), .HAS_FUNDAMENTAL(1'b0)) dutNf_u (
        .clk, .reset, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData(rdDataNf), .irq(),
        .zeroCrossIc(ev[0]), .dipPhase(ev[3:1]), .excessCurrentPhase(ev[6:4]),
        .excessVoltagePhase(ev[9:7]), .riseVa(ev[10]), .riseVb(ev[11]), .riseVc(ev[12]),
        .sampleValid(ev[13]), .phaseCurrentSum, .neutralCurrentWave, .currentPeakDone(ev[14]),
        .voltagePeakDone(ev[15]), .totalIdle, .fundIdle, .apparentIdle);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1 chk(rdData, exp);
    endtask
    // reset-done status bit 15 can never be masked
    task automatic irqchk;
        #1 chk({31'h0, irq}, {31'h0, (expStat & (expMask | 32'h8000)) != 0});
    endtask
    task automatic setm(input logic [31:0] d);
        wr(meter_event_pkg::ADDR_EVENT_ENABLE_SECOND, d);
        expMask = d & 32'h019F_FFFF;
    endtask
    // clearing a level status also clears its phase group
    task automatic clr(input logic [31:0] c);
        wr(meter_event_pkg::ADDR_EVENT_STATUS_SECOND, c);
        expStat &= ~c;
        for (int g = 0; g < 3; g++) begin
            if (c[16+g]) expSrc &= ~(7 << srcLsb[g]);
        end
    endtask
    task automatic pulse(input logic [15:0] e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= 16'h0000;
    endtask
    task automatic mism(input int s, input int n);
        int d;
        d = (s < 0 ? -s : s) - (n < 0 ? -n : n);
        phaseCurrentSum <= 24'(s);
        neutralCurrentWave <= 24'(n);
        pulse(16'h2000);
        if (d > 10 || d < -10) expStat |= 32'h0010_0000;
    endtask
    task automatic stop_test;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        stop_test();
    end
    initial begin
        v = $urandom(41);
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        expStat = 32'h0000_8000;
        rdchk(meter_event_pkg::ADDR_EVENT_ENABLE_SECOND, 0);
        rdchk(meter_event_pkg::ADDR_PHASE_EVENT_SOURCE, 0);
        rdchk(meter_event_pkg::ADDR_PHASE_IDLE_STATE, 0);
        rdchk(16'hE5FF, 0);
        irqchk();
        rdchk(meter_event_pkg::ADDR_EVENT_STATUS_SECOND, expStat);
        clr(32'h0000_8000);
        for (int i = 0; i < 6; i++) begin
            setm(i == 5 ? 32'hFFFF_FFFF : $urandom());
            rdchk(meter_event_pkg::ADDR_EVENT_ENABLE_SECOND, expMask);
            irqchk();
        end
        for (int g = 0; g < 3; g++) begin
            for (int p = 0; p < 3; p++) begin
                setm(p == 1 ? 0 : 1 << (16 + g));
                pulse(16'h1 << (1 + 3 * g + p));
                expStat |= 1 << (16 + g);
                expSrc |= 1 << (srcLsb[g] + p);
                irqchk();
                rdchk(meter_event_pkg::ADDR_PHASE_EVENT_SOURCE, expSrc);
            end
            clr(1 << (16 + g));
            rdchk(meter_event_pkg::ADDR_PHASE_EVENT_SOURCE, expSrc);
        end
        for (int i = 0; i < 3; i++) begin
            setm(1 << stBit[i]);
            pulse(16'h1 << evBit[i]);
            expStat |= 1 << stBit[i];
            irqchk();
            clr(1 << stBit[i]);
            irqchk();
        end
        setm(32'h0008_0000);
        pulse(16'h0400);
        pulse(16'h0800);
        pulse(16'h1000);
        irqchk();
        pulse(16'h0400);
        pulse(16'h1000);
        expStat |= 32'h0008_0000;
        irqchk();
        clr(32'h0008_0000);
        wr(meter_event_pkg::ADDR_CURRENT_SUM_LIMIT, 32'h0000_000A);
        setm(32'h0010_0000);
        for (int i = 0; i < 8; i++) begin
            mism(i == 0 ? 20 : int'($urandom_range(60)) - 30, i == 0 ? -10 : -15);
            irqchk();
            clr(32'h0010_0000);
        end
        setm(32'h0000_0001);
        for (int i = 0; i < 7; i++) begin
            v = (i == 6) ? 0 : $urandom();
            @(posedge clk);
            if (|(v[2:0] & ~totalIdle)) expStat |= 1;
            if (|(v[5:3] & ~fundIdle)) expStat |= 2;
            if (|(v[8:6] & ~apparentIdle)) expStat |= 4;
            {apparentIdle, fundIdle, totalIdle} <= v[8:0];
            repeat (2) @(posedge clk);
            rdchk(meter_event_pkg::ADDR_PHASE_IDLE_STATE, v[8:0]);
            chk(rdDataNf, v[8:0] & 32'h0000_01C7);
            rdchk(meter_event_pkg::ADDR_EVENT_STATUS_SECOND, expStat);
            irqchk();
            clr(32'h0000_0007);
        end
        stop_test();
    end
endmodule
